/* pkg/fccrc_pkg.sv */
// Purpose: Shared constants for the flash command interpreter and CRC check
// Assumes: Opcodes and device-state codes are byte and two-bit values
// Notes:   Operation classes come from the outside opcode classifier
package fccrc_pkg;
  // Command codes
  localparam logic [7:0] OP_ENTER_ADDR4 = 8'hb7;
  localparam logic [7:0] OP_EXIT_ADDR4  = 8'he9;
  localparam logic [7:0] OP_ENTER_QUAD  = 8'h35;
  localparam logic [7:0] OP_RESET_QUAD  = 8'hf5;
  localparam logic [7:0] OP_CRC         = 8'h9b;
  localparam logic [7:0] SUB_CRC        = 8'h27;
  localparam logic [7:0] OPT_CRC_ALL    = 8'hff;
  localparam logic [7:0] OPT_CRC_RANGE  = 8'hfe;
  // Byte positions within a frame, counted from zero
  localparam logic [4:0] IDX_SUB        = 5'h01;
  localparam logic [4:0] IDX_OPT        = 5'h02;
  localparam logic [4:0] IDX_EXP_FIRST  = 5'h03;
  localparam logic [4:0] IDX_EXP_LAST   = 5'h0a;
  localparam logic [4:0] IDX_START_LAST = 5'h0e;
  localparam logic [4:0] IDX_STOP_LAST  = 5'h12;
  localparam logic [4:0] IDX_ADDR3_LAST = 5'h03;
  localparam logic [4:0] IDX_ADDR4_LAST = 5'h04;
  // CRC-64 generator, x^64 implied
  localparam logic [63:0] CRC_POLY      = 64'h42f0e1eba9ea3693;
  localparam logic [63:0] CRC_INIT      = 64'h0000000000000000;
  // Flag status bit positions and reset values
  localparam int          FSR_READY_BIT = 7;
  localparam int          FSR_FAIL_BIT  = 4;
  localparam logic        RST_ADDR4     = 1'b0;
  localparam logic        RST_QUAD      = 1'b0;
  localparam logic        RST_READY     = 1'b1;
  // Device states reported by the program/erase engine
  localparam logic [1:0] DST_STANDBY    = 2'h0;
  localparam logic [1:0] DST_BUSY       = 2'h1;
  localparam logic [1:0] DST_SUB_PSUSP  = 2'h2;
  localparam logic [1:0] DST_ERS_SUSP   = 2'h3;
  // Operation classes
  localparam logic [2:0] CLS_READ       = 3'h0;
  localparam logic [2:0] CLS_READ_SR    = 3'h1;
  localparam logic [2:0] CLS_PROGRAM    = 3'h2;
  localparam logic [2:0] CLS_ERASE      = 3'h3;
  localparam logic [2:0] CLS_WR_NV      = 3'h4;
  localparam logic [2:0] CLS_WR_VOL     = 3'h5;
  localparam logic [2:0] CLS_SUSPEND    = 3'h6;
  localparam logic [2:0] CLS_OTHER      = 3'h7;
  // CRC engine states, one-hot
  typedef enum logic [2:0] {
    CRS_IDLE  = 3'b001,
    CRS_FETCH = 3'b010,
    CRS_WAIT  = 3'b100
  } fccrc_crs_e;
endpackage

/* src/fccrc_top.sv */
// Purpose: Command interpreter of a serial NOR flash: address/quad modes,
//          state-table gating of operations and the CRC-64 array check
// Assumes: Serial clock, select and data pins are oversampled by clk
// Notes:   Data are taken on serial clock rising edges, MSB first per byte
`timescale 1ns/1ps
module fccrc_top import fccrc_pkg::*; #(
  parameter int ADDR_W  = 24,
  parameter int SECT_LO = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Serial pins
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic [3:0]        serial_data_lines,
  // Device state from the program/erase engine, operation class and flag clear
  input  wire logic [1:0]        dev_state,
  input  wire logic [ADDR_W-1:SECT_LO] susp_sector,
  input  wire logic [2:0]        op_class,
  input  wire logic              flag_clear,
  // Command decisions
  output logic                   cmd_byte_p,
  output logic [7:0]             cmd_code_r,
  output logic [31:0]            cmd_addr_r,
  output logic                   cmd_accept_p,
  output logic                   cmd_reject_p,
  // Modes and flags
  output logic                   addr4_r,
  output logic                   quad_r,
  output logic [7:0]             flag_status,
  // Array read port for the CRC engine
  output logic                   mem_req,
  output logic [ADDR_W-1:0]      mem_addr_r,
  input  wire logic [7:0]        mem_rdata,
  input  wire logic              mem_rvalid
);

  if (ADDR_W < SECT_LO + 1 || ADDR_W > 32) begin : g_addr_w_check
    $error("fccrc_top: ADDR_W out of range");
  end

  // One byte through the serial CRC, LSB first
  function automatic logic [63:0] crc_byte(input logic [63:0] c, input logic [7:0] d);
    logic [63:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[63] ^ d[i];
      r  = {r[62:0], 1'b0} ^ (fb ? CRC_POLY : 64'h0);
    end
    return r;
  endfunction

  // State table lookup
  function automatic logic allowed(input logic [2:0] cls, input logic [1:0] st,
                                   input logic same_sec);
    case (cls)
      CLS_READ:    allowed = (st != DST_BUSY);
      CLS_READ_SR: allowed = 1'b1;
      CLS_PROGRAM: allowed = (st == DST_STANDBY) ||
                             (st == DST_ERS_SUSP && !same_sec);
      CLS_ERASE:   allowed = (st == DST_STANDBY);
      CLS_WR_NV:   allowed = (st == DST_STANDBY);
      CLS_WR_VOL:  allowed = (st != DST_BUSY);
      CLS_SUSPEND: allowed = (st == DST_BUSY);
      default:     allowed = (st == DST_STANDBY);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one feeds stage two only
  logic       cs_s1, cs_s2, cs_s3, ck_s1, ck_s2, ck_s3;
  logic [3:0] dq_s1, dq_s2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {ck_s1, ck_s2, ck_s3} <= 3'h0;
      dq_s1 <= 4'h0;
      dq_s2 <= 4'h0;
    end else begin
      {cs_s1, cs_s2, cs_s3} <= {cs_n, cs_s1, cs_s2};
      {ck_s1, ck_s2, ck_s3} <= {sclk, ck_s1, ck_s2};
      dq_s1 <= serial_data_lines;
      dq_s2 <= dq_s1;
    end
  end
  logic sck_rise, cs_rise;
  assign sck_rise = ck_s2 & ~ck_s3 & ~cs_s2;
  assign cs_rise  = cs_s2 & ~cs_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Byte assembly: one line, or four lines in quad protocol
  logic [7:0] sh_r, sh_nxt, rx_byte_r;
  logic [2:0] bc_r, bc_nxt;
  logic       byte_p_r;
  logic [4:0] idx_r;
  always_comb begin
    sh_nxt = quad_r ? {sh_r[3:0], dq_s2} : {sh_r[6:0], dq_s2[0]};
    bc_nxt = bc_r + (quad_r ? 3'h4 : 3'h1);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= 8'h00;
      bc_r <= 3'h0;
      byte_p_r <= 1'b0;
      rx_byte_r <= 8'h00;
    end else begin
      byte_p_r <= 1'b0;
      if (cs_s2) begin
        bc_r <= 3'h0;
      end else if (sck_rise) begin
        sh_r <= sh_nxt;
        bc_r <= bc_nxt;
        if (bc_nxt == 3'h0) begin
          byte_p_r  <= 1'b1;
          rx_byte_r <= sh_nxt;
        end
      end
    end
  end
  // Byte index within the frame, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_r <= 5'h00;
    end else if (cs_s2) begin
      idx_r <= 5'h00;
    end else if (byte_p_r && idx_r != 5'h1f) begin
      idx_r <= idx_r + 5'h01;
    end
  end
  logic first_p;
  assign first_p    = byte_p_r && idx_r == 5'h00;
  assign cmd_byte_p = first_p;

  ////////////////////////////////////////////////////////////////////////////
  // Mode latches take effect on the byte's last edge, no select rise needed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr4_r <= RST_ADDR4;
      quad_r  <= RST_QUAD;
    end else if (first_p) begin
      if (rx_byte_r == OP_ENTER_ADDR4) addr4_r <= 1'b1;
      if (rx_byte_r == OP_EXIT_ADDR4)  addr4_r <= 1'b0;
      if (rx_byte_r == OP_ENTER_QUAD)  quad_r  <= 1'b1;
      if (rx_byte_r == OP_RESET_QUAD)  quad_r  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command gating: programs wait for their address to check the sector
  logic       pend_r, addr_wait_r;
  logic [2:0] cls_r;
  logic       same_sec;
  assign same_sec = cmd_addr_r[ADDR_W-1:SECT_LO] == susp_sector;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_code_r <= 8'h00;
      cmd_addr_r <= 32'h0;
      pend_r <= 1'b0;
      addr_wait_r <= 1'b0;
      cls_r <= CLS_OTHER;
      cmd_accept_p <= 1'b0;
      cmd_reject_p <= 1'b0;
    end else begin
      cmd_accept_p <= 1'b0;
      cmd_reject_p <= 1'b0;
      pend_r <= first_p;
      if (first_p) begin
        cmd_code_r <= rx_byte_r;
        addr_wait_r <= 1'b0;
      end
      if (byte_p_r && idx_r != 5'h00) cmd_addr_r <= {cmd_addr_r[23:0], rx_byte_r};
      if (pend_r && cmd_code_r != OP_CRC) begin
        cls_r <= op_class;
        if (op_class == CLS_PROGRAM) begin
          addr_wait_r <= 1'b1;
        end else begin
          // Refused commands only pulse reject; engines act on accept
          cmd_accept_p <= allowed(op_class, dev_state, 1'b0);
          cmd_reject_p <= !allowed(op_class, dev_state, 1'b0);
        end
      end else if (addr_wait_r && !byte_p_r && !cs_s2 && // Whole address is in
                   idx_r == (addr4_r ? IDX_ADDR4_LAST : IDX_ADDR3_LAST) + 5'h01) begin
        addr_wait_r  <= 1'b0;
        cmd_accept_p <= allowed(cls_r, dev_state, same_sec);
        cmd_reject_p <= !allowed(cls_r, dev_state, same_sec);
      end else if (cs_s2) begin
        addr_wait_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CRC sequence capture, fields arrive LSB first
  logic [63:0] exp_r;
  logic [31:0] start_r, stop_r;
  logic        seq_ok_r, range_r, armed_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_r <= 64'h0;
      start_r <= 32'h0;
      stop_r <= 32'h0;
      seq_ok_r <= 1'b0;
      range_r <= 1'b0;
      armed_r <= 1'b0;
    end else if (cs_s2) begin
      seq_ok_r <= 1'b0;
      armed_r <= 1'b0;
    end else if (byte_p_r) begin
      if (idx_r == 5'h00) seq_ok_r <= (rx_byte_r == OP_CRC);
      if (idx_r == IDX_SUB && rx_byte_r != SUB_CRC) seq_ok_r <= 1'b0;
      if (idx_r == IDX_OPT) begin
        range_r <= (rx_byte_r == OPT_CRC_RANGE);
        if (rx_byte_r != OPT_CRC_RANGE && rx_byte_r != OPT_CRC_ALL) seq_ok_r <= 1'b0;
      end
      if (idx_r >= IDX_EXP_FIRST && idx_r <= IDX_EXP_LAST)
        exp_r <= {rx_byte_r, exp_r[63:8]};
      if (idx_r > IDX_EXP_LAST && idx_r <= IDX_START_LAST)
        start_r <= {rx_byte_r, start_r[31:8]};
      if (idx_r > IDX_START_LAST && idx_r <= IDX_STOP_LAST)
        stop_r <= {rx_byte_r, stop_r[31:8]};
      // Exactly the full sequence arms; a longer frame disarms
      armed_r <= seq_ok_r && (idx_r == (range_r ? IDX_STOP_LAST : IDX_EXP_LAST));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CRC engine: one array byte per request, started by select rising
  fccrc_crs_e        crs_r;
  logic [63:0]       crc_r;
  logic [ADDR_W-1:0] end_r;
  logic              fail_r, ready_r, go;
  assign go      = cs_rise && armed_r && crs_r == CRS_IDLE;
  assign mem_req = (crs_r == CRS_FETCH);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crs_r <= CRS_IDLE;
      crc_r <= CRC_INIT;
      mem_addr_r <= '0;
      end_r <= '0;
    end else begin
      case (crs_r)
        CRS_IDLE: if (go) begin
          crc_r <= CRC_INIT;
          mem_addr_r <= range_r ? start_r[ADDR_W-1:0] : '0;
          end_r <= range_r ? stop_r[ADDR_W-1:0] : '1;
          crs_r <= (range_r && start_r > stop_r) ? CRS_IDLE : CRS_FETCH;
        end
        CRS_FETCH: crs_r <= CRS_WAIT;
        CRS_WAIT: if (mem_rvalid) begin
          crc_r <= crc_byte(crc_r, mem_rdata);
          mem_addr_r <= mem_addr_r + 1'b1;
          crs_r <= (mem_addr_r == end_r) ? CRS_IDLE : CRS_FETCH;
        end
        default: crs_r <= CRS_IDLE;
      endcase
    end
  end
  logic crc_done;
  assign crc_done = (crs_r == CRS_WAIT && mem_rvalid && mem_addr_r == end_r) ||
                    (go && range_r && start_r > stop_r);

  ////////////////////////////////////////////////////////////////////////////
  // Flag status: bit 7 ready, bit 4 CRC fail; a set beats a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_r  <= 1'b0;
      ready_r <= RST_READY;
    end else begin
      ready_r <= (crs_r == CRS_IDLE) && !go && dev_state != DST_BUSY;
      if (crc_done) begin
        fail_r <= (crs_r == CRS_WAIT ? crc_byte(crc_r, mem_rdata) : CRC_INIT)
                  != exp_r;
      end else if (flag_clear) begin
        fail_r <= 1'b0;
      end
    end
  end
  always_comb begin
    flag_status = 8'h00;
    flag_status[FSR_READY_BIT] = ready_r;
    flag_status[FSR_FAIL_BIT]  = fail_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_addr4_enter: assert property (@(posedge clk) disable iff (!rst_n)
    first_p && rx_byte_r == OP_ENTER_ADDR4 |=> addr4_r) else $error("enter addr4 missed");
  a_addr4_exit: assert property (@(posedge clk) disable iff (!rst_n)
    first_p && rx_byte_r == OP_EXIT_ADDR4 |=> !addr4_r) else $error("exit addr4 missed");
  a_quad_modes: assert property (@(posedge clk) disable iff (!rst_n)
    first_p && (rx_byte_r == OP_ENTER_QUAD || rx_byte_r == OP_RESET_QUAD)
    |=> quad_r == ($past(rx_byte_r) == OP_ENTER_QUAD)) else $error("quad mode wrong");
  a_crc_start: assert property (@(posedge clk) disable iff (!rst_n)
    crs_r == CRS_IDLE ##1 crs_r == CRS_FETCH |-> $past(cs_rise) && $past(armed_r))
    else $error("CRC started without select rise");
  a_crc_init: assert property (@(posedge clk) disable iff (!rst_n)
    crs_r == CRS_IDLE ##1 crs_r == CRS_FETCH |-> crc_r == CRC_INIT)
    else $error("CRC not cleared at start");
  a_ready_low: assert property (@(posedge clk) disable iff (!rst_n)
    crs_r != CRS_IDLE ##1 crs_r != CRS_IDLE |-> !ready_r) else $error("ready high while busy");
  a_read_busy: assert property (@(posedge clk) disable iff (!rst_n)
    pend_r && op_class == CLS_READ && dev_state == DST_BUSY && cmd_code_r != OP_CRC
    |=> cmd_reject_p && !cmd_accept_p) else $error("read accepted while busy");
  a_susp_gate: assert property (@(posedge clk) disable iff (!rst_n)
    pend_r && op_class == CLS_SUSPEND && cmd_code_r != OP_CRC
    |=> cmd_accept_p == ($past(dev_state) == DST_BUSY)) else $error("suspend gating wrong");
  a_erase_stby: assert property (@(posedge clk) disable iff (!rst_n)
    pend_r && op_class == CLS_ERASE && cmd_code_r != OP_CRC
    |=> cmd_accept_p == ($past(dev_state) == DST_STANDBY)) else $error("erase gating wrong");
  a_crc_result: assert property (@(posedge clk) disable iff (!rst_n)
    crc_done && !flag_clear |=> fail_r == (crc_r != exp_r))
    else $error("CRC fail flag wrong");

endmodule

/* bench/fccrc_host_model.sv */
// Purpose: Host and array model on the far side of the command block
// Assumes: Everything changes on the falling clk edge
// Notes:   Released data lines show the inverse of their last value
`timescale 1ns/1ps
module fccrc_host_model (
  // Clock
  input  wire logic        clk,
  // Serial pins
  output logic             cs_n,
  output logic             sclk,
  output logic [3:0]       serial_data_lines,
  // Array read port
  input  wire logic        mem_req,
  input  wire logic [11:0] mem_addr_r,
  output logic [7:0]       mem_rdata,
  output logic             mem_rvalid
);
  logic        pend_r;
  logic [11:0] addr_r;

  // Idle levels; serial clock stands still low outside frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    serial_data_lines = 4'h0;
    mem_rdata = 8'h00;
    mem_rvalid = 1'b0;
    pend_r = 1'b0;
    addr_r = 12'h000;
  end

  // Array contents, a fixed pattern of the address
  function automatic logic [7:0] pattern(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Array answers one idle cycle late, so the wait state is exercised
  // Every request is caught, even one raised while the last answer stands
  always @(negedge clk) begin
    mem_rvalid <= pend_r;
    mem_rdata  <= pend_r ? pattern(addr_r) : ~mem_rdata; // Stale data never lingers
    pend_r     <= mem_req;
    if (mem_req) addr_r <= mem_addr_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One serial clock of 200 ns, data set while the clock is low
  task automatic put_bits(input logic [3:0] v);
    serial_data_lines = v;
    sclk = 1'b0;
    repeat (4) @(negedge clk);
    sclk = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // No write enable precedes any code; bytes go MSB first
  task automatic send_byte(input logic [7:0] b, input logic quad);
    int i;
    if (quad) begin
      put_bits(b[7:4]);
      put_bits(b[3:0]);
    end else begin
      for (i = 7; i >= 0; i--) put_bits({~b[i], ~b[i], ~b[i], b[i]});
    end
  endtask

  task automatic open_frame();
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Select rises only after the last byte has been taken
  task automatic close_frame();
    repeat (8) @(negedge clk);
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_data_lines = ~serial_data_lines;
    repeat (8) @(negedge clk);
  endtask
endmodule

/* bench/test_flash_cmd_state_crc_check.sv */
// Purpose: Self-checking bench for the flash command block
// Assumes: Array narrowed to 12 address bits so whole checks stay short
// Notes:   Operation class is driven by the bench in place of a decoder
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_flash_cmd_state_crc_check import fccrc_pkg::*;;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n, sclk, flag_clear = 1'b0;
  logic [3:0]  sdl;
  logic [1:0]  dev_state = DST_STANDBY;
  logic [11:8] susp_sector = 4'h0;
  logic [2:0]  op_class = CLS_OTHER;
  logic        byte_p, acc_p, rej_p, addr4, quad, mem_req, rvalid;
  logic [7:0]  code, flags, rdata;
  logic [31:0] caddr;
  logic [11:0] maddr;
  int          errors, compares, n_acc, n_rej, n_byte, cycles;

  fccrc_top #(.ADDR_W(12), .SECT_LO(8)) fccrc_top_inst (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
    .serial_data_lines(sdl), .dev_state(dev_state),
    .susp_sector(susp_sector), .op_class(op_class), .flag_clear(flag_clear),
    .cmd_byte_p(byte_p), .cmd_code_r(code), .cmd_addr_r(caddr),
    .cmd_accept_p(acc_p), .cmd_reject_p(rej_p), .addr4_r(addr4),
    .quad_r(quad), .flag_status(flags), .mem_req(mem_req),
    .mem_addr_r(maddr), .mem_rdata(rdata), .mem_rvalid(rvalid));

  fccrc_host_model fccrc_host_model_inst (
    .clk(clk), .cs_n(cs_n), .sclk(sclk), .serial_data_lines(sdl),
    .mem_req(mem_req), .mem_addr_r(maddr), .mem_rdata(rdata),
    .mem_rvalid(rvalid));

  always #12.5 clk = ~clk;

  // Pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    if (acc_p === 1'b1) n_acc++;
    if (rej_p === 1'b1) n_rej++;
    if (byte_p === 1'b1) n_byte++;
    cycles++;
    if (cycles == 60000) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, cycles, 0);
      conclude();
    end
  end

  task automatic conclude();
    $display("counts: compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic frame(input logic [7:0] b, input logic q);
    fccrc_host_model_inst.open_frame();
    fccrc_host_model_inst.send_byte(b, q);
    fccrc_host_model_inst.close_frame();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_modes();
    `CHK(flags, 8'h80)
    `CHK({addr4, quad}, 2'b00)
    frame(OP_ENTER_QUAD, 1'b0);
    `CHK(quad, 1'b1)
    frame(OP_ENTER_ADDR4, 1'b1);
    `CHK(addr4, 1'b1)
    frame(OP_RESET_QUAD, 1'b1);
    `CHK(quad, 1'b0)
    frame(OP_EXIT_ADDR4, 1'b0);
    `CHK(addr4, 1'b0)
    `CHK(code, OP_EXIT_ADDR4)
    $display("test modes done");
  endtask

  // Accept map per state, bit n for class n; program is judged apart
  task automatic t_gate();
    logic [7:0] tbl [4];
    int s, c, a0, r0, e;
    tbl = '{8'hbf, 8'h42, 8'h23, 8'h27};
    for (s = 0; s < 4; s++) begin
      for (c = 0; c < 8; c++) begin
        if (c == 2) continue;
        dev_state = s[1:0];
        op_class = c[2:0];
        a0 = n_acc;
        r0 = n_rej;
        frame(8'h05, 1'b0);
        e = tbl[s][c];
        `CHK(n_acc - a0, e)
        `CHK(n_rej - r0, 1 - e)
      end
    end
    $display("test gating done");
  endtask

  // Program to the suspended sector is refused, its neighbour is not;
  // the last pass is in four-byte mode, so the decision must await byte four
  task automatic t_prog();
    logic [1:0] st [5];
    logic [3:0] sec [5];
    int i, a0, r0, b0, e;
    st = '{DST_ERS_SUSP, DST_ERS_SUSP, DST_SUB_PSUSP, DST_STANDBY, DST_ERS_SUSP};
    sec = '{4'h5, 4'h6, 4'h5, 4'h5, 4'h5};
    susp_sector = 4'h5;
    op_class = CLS_PROGRAM;
    for (i = 0; i < 5; i++) begin
      if (i == 4) frame(OP_ENTER_ADDR4, 1'b0);
      dev_state = st[i];
      a0 = n_acc;
      r0 = n_rej;
      b0 = n_byte;
      e = (i % 2);
      fccrc_host_model_inst.open_frame();
      fccrc_host_model_inst.send_byte(8'h02, 1'b0);
      if (i == 4) fccrc_host_model_inst.send_byte(8'h00, 1'b0);
      fccrc_host_model_inst.send_byte(8'h00, 1'b0);
      fccrc_host_model_inst.send_byte({4'h0, sec[i]}, 1'b0);
      fccrc_host_model_inst.send_byte(8'h12, 1'b0);
      fccrc_host_model_inst.close_frame();
      `CHK(n_acc - a0, e)
      `CHK(n_rej - r0, 1 - e)
      `CHK(n_byte - b0, 1)
      `CHK(caddr[15:0], {4'h0, sec[i], 8'h12})
    end
    frame(OP_EXIT_ADDR4, 1'b0);
    `CHK(addr4, 1'b0)
    dev_state = DST_STANDBY;
    op_class = CLS_OTHER;
    $display("test program gating done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_crc(input logic rng, input logic [11:0] lo, input logic [11:0] hi,
                       input logic bad);
    logic [63:0] crc;
    logic [7:0]  d;
    logic [31:0] lo32, hi32;
    int a, i, n;
    crc = CRC_INIT;
    lo32 = {20'h0, lo};
    hi32 = {20'h0, hi};
    for (a = lo; a <= hi; a++) begin
      d = fccrc_host_model_inst.pattern(a[11:0]);
      for (i = 0; i < 8; i++) begin
        crc = {crc[62:0], 1'b0} ^ ((crc[63] ^ d[i]) ? CRC_POLY : 64'h0);
      end
    end
    crc = crc ^ {63'h0, bad};
    fccrc_host_model_inst.open_frame();
    fccrc_host_model_inst.send_byte(OP_CRC, 1'b0);
    fccrc_host_model_inst.send_byte(SUB_CRC, 1'b0);
    fccrc_host_model_inst.send_byte(rng ? OPT_CRC_RANGE : OPT_CRC_ALL, 1'b0);
    for (i = 0; i < 8; i++) fccrc_host_model_inst.send_byte(crc[8*i+:8], 1'b0);
    if (rng) begin
      for (i = 0; i < 4; i++) fccrc_host_model_inst.send_byte(lo32[8*i+:8], 1'b0);
      for (i = 0; i < 4; i++) fccrc_host_model_inst.send_byte(hi32[8*i+:8], 1'b0);
    end
    `CHK(flags[7], 1'b1)
    fccrc_host_model_inst.close_frame();
    `CHK(flags[7], 1'b0)
    n = 0;
    while (flags[7] !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    `CHK(flags[7], 1'b1)
    `CHK(maddr, hi + 12'h001)
    `CHK(flags[4], bad)
    $display("test crc done");
  endtask

  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_modes();
    t_gate();
    t_prog();
    t_crc(1'b0, 12'h000, 12'hfff, 1'b0);
    t_crc(1'b1, 12'h010, 12'h02f, 1'b1);
    t_crc(1'b1, 12'h3f0, 12'h41f, 1'b0);
    t_crc(1'b1, 12'h010, 12'h02f, 1'b1);
    flag_clear = 1'b1;
    @(negedge clk);
    flag_clear = 1'b0;
    @(negedge clk);
    `CHK(flags[4], 1'b0)
    conclude();
  end
endmodule
